// ### abu_breakpoint.sv
// Purpose: address breakpoint unit with software break and flag protection
// Assumes: the cpu qualifies program addresses and marks opcode fetches
// Notes:   registers are read and written over classic wishbone
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ps
module abu_breakpoint (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        clkEn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [15:0] cpuAddr,
  input  wire logic        cpuAddrValid,
  input  wire logic        cpuOpcodeFetch,
  input  wire logic        cpuInstrStart,
  input  wire logic        cpuSwiStart,
  input  wire logic        cpuRtiDone,
  input  wire logic        lowPowerMode,
  input  wire logic        waitExit,
  input  wire logic        monitorMode,
  input  wire logic        highTestVoltagePin,
  output logic             breakpointRequest,
  output logic             breakBeforeOpcode,
  output logic      [7:0]  injectOpcode,
  output logic      [15:0] breakVector,
  output logic             breakState,
  output logic             statusClearAllowed,
  output logic             timerFreeze,
  output logic             watchdogDisable,
  output logic             irq
);
  import abu_pkg::*;

  typedef struct packed {
    logic [7:0] addrHigh;
    logic [7:0] addrLow;
    logic       enable;
    logic       active;
    logic       clearEnable;
    logic       waitBreak;
    logic       request;
    logic       reqOpcode;
    logic       pendingOperand;
    logic       forcePending;
    logic       inBreak;
    logic       matchSeen;
    logic [1:0] irqStatus;
    logic [1:0] irqMask;
    logic       ack;
    logic [7:0] rdata;
    logic       vtstS1;
    logic       vtstS2;
  } abu_state_t;

  abu_state_t stQ;
  abu_state_t stD;

  function automatic logic hitReg(input logic [15:0] a, input logic [15:0] off);
    hitReg = (a == off);
  endfunction : hitReg

  logic        busReq;
  logic        wrStb;
  logic        rdStb;
  logic        addrMatch;
  logic [7:0]  wByte;

  assign busReq = wb_cyc_i && wb_stb_i && !stQ.ack;
  assign wrStb  = busReq && wb_we_i && wb_sel_i[0];
  assign rdStb  = busReq && !wb_we_i;
  assign wByte  = wb_dat_i[7:0];
  // an idle bus in wait or stop never advances, so no match is counted there
  assign addrMatch = stQ.enable && cpuAddrValid && !lowPowerMode &&
                     (cpuAddr == {stQ.addrHigh, stQ.addrLow});

  always_comb begin
    stD     = stQ;
    stD.ack = 1'b0;
    stD.vtstS1 = highTestVoltagePin;
    stD.vtstS2 = stQ.vtstS1;
    if (busReq) begin
      stD.ack = 1'b1;
    end
    if (rdStb) begin
      stD.rdata = RESET_BYTE;
      if (hitReg(wb_adr_i, OFF_WAIT_EXIT)) stD.rdata[BIT_WAIT_BREAK] = stQ.waitBreak;
      if (hitReg(wb_adr_i, OFF_FLAG_PROT)) stD.rdata[BIT_CLEAR_EN] = stQ.clearEnable;
      if (hitReg(wb_adr_i, OFF_ADDR_HIGH)) stD.rdata = stQ.addrHigh;
      if (hitReg(wb_adr_i, OFF_ADDR_LOW))  stD.rdata = stQ.addrLow;
      if (hitReg(wb_adr_i, OFF_CTRL_STAT)) begin
        stD.rdata[BIT_ENABLE] = stQ.enable;
        stD.rdata[BIT_ACTIVE] = stQ.active;
      end
      if (hitReg(wb_adr_i, OFF_IRQ_STATUS)) begin
        stD.rdata = {6'h0, stQ.irqStatus};
        // a debugger peeking in break must not lose events unless it asked to
        if (!stQ.inBreak || stQ.clearEnable) stD.irqStatus = 2'h0;
      end
      if (hitReg(wb_adr_i, OFF_IRQ_MASK)) stD.rdata = {6'h0, stQ.irqMask};
    end
    if (wrStb) begin
      if (hitReg(wb_adr_i, OFF_ADDR_HIGH)) stD.addrHigh = wByte;
      if (hitReg(wb_adr_i, OFF_ADDR_LOW))  stD.addrLow  = wByte;
      if (hitReg(wb_adr_i, OFF_FLAG_PROT)) stD.clearEnable = wByte[BIT_CLEAR_EN];
      if (hitReg(wb_adr_i, OFF_IRQ_MASK))  stD.irqMask = wByte[1:0];
      if (hitReg(wb_adr_i, OFF_WAIT_EXIT) && !wByte[BIT_WAIT_BREAK] &&
          (!stQ.inBreak || stQ.clearEnable)) begin
        stD.waitBreak = 1'b0;
      end
      if (hitReg(wb_adr_i, OFF_CTRL_STAT)) begin
        stD.enable = wByte[BIT_ENABLE];
        if (wByte[BIT_ACTIVE]) begin
          stD.active       = 1'b1;
          stD.forcePending = 1'b1;
        end else begin
          stD.active = 1'b0;
        end
      end
    end
    // a taken address stays disarmed until software rewrites either address byte;
    // clearing only the active bit is not enough to re-arm the same address
    if (wrStb && (hitReg(wb_adr_i, OFF_ADDR_HIGH) || hitReg(wb_adr_i, OFF_ADDR_LOW))) begin
      stD.matchSeen = 1'b0;
    end
    if (addrMatch && !stQ.matchSeen && !stQ.inBreak && !stQ.request) begin
      stD.matchSeen = 1'b1;
      stD.active    = 1'b1;
      stD.irqStatus[IRQ_BREAK] = 1'b1;
      if (cpuOpcodeFetch) begin
        stD.request   = 1'b1;
        stD.reqOpcode = 1'b1;
      end else begin
        stD.pendingOperand = 1'b1;
      end
    end
    if ((stQ.pendingOperand || stQ.forcePending) && cpuInstrStart && !stQ.request) begin
      stD.request        = 1'b1;
      stD.reqOpcode      = 1'b0;
      stD.pendingOperand = 1'b0;
      stD.forcePending   = 1'b0;
      stD.irqStatus[IRQ_BREAK] = 1'b1;
    end
    if (stQ.request && cpuSwiStart) begin
      stD.request = 1'b0;
      stD.inBreak = 1'b1;
    end
    if (stQ.inBreak && cpuRtiDone) stD.inBreak = 1'b0;
    if (waitExit && (stQ.request || stQ.forcePending)) begin
      stD.waitBreak = 1'b1;
      stD.irqStatus[IRQ_WAIT_EXIT] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stQ <= '0;
    end else if (clkEn) begin
      stQ <= stD;
    end
  end

  assign wb_ack_o           = stQ.ack;
  assign wb_dat_o           = {24'h0, stQ.rdata};
  assign breakpointRequest  = stQ.request;
  assign breakBeforeOpcode  = stQ.request && stQ.reqOpcode;
  assign injectOpcode       = SWI_OPCODE;
  assign breakVector        = monitorMode ? VEC_MONITOR : VEC_NORMAL;
  assign breakState         = stQ.inBreak;
  assign statusClearAllowed = !stQ.inBreak || stQ.clearEnable;
  assign timerFreeze        = stQ.inBreak;
  assign watchdogDisable    = stQ.inBreak && stQ.vtstS2;
  assign irq                = |(stQ.irqStatus & stQ.irqMask);

  property p_req_held;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && stQ.request && !cpuSwiStart) |=> stQ.request;
  endproperty
  a_req_held: assert property (p_req_held) else $error("request dropped early");

  property p_swi_ends_req;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && stQ.request && cpuSwiStart) |=> (!stQ.request && stQ.inBreak);
  endproperty
  a_swi_ends_req: assert property (p_swi_ends_req) else $error("swi did not enter break");

  property p_freeze;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && stQ.request && cpuSwiStart) |=> timerFreeze;
  endproperty
  a_freeze: assert property (p_freeze) else $error("timer not frozen in break");

  property p_clear_block;
    @(posedge clk) disable iff (!rst_n)
      (stQ.inBreak && !stQ.clearEnable) |-> !statusClearAllowed;
  endproperty
  a_clear_block: assert property (p_clear_block) else $error("clear allowed while blocked");

  property p_rti;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && stQ.inBreak && cpuRtiDone) |=> !stQ.inBreak;
  endproperty
  a_rti: assert property (p_rti) else $error("return did not end break");

  property p_no_lowpower_match;
    @(posedge clk) disable iff (!rst_n) lowPowerMode |-> !addrMatch;
  endproperty
  a_no_lowpower_match: assert property (p_no_lowpower_match) else $error("match in low power");

  property p_opcode_match;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && addrMatch && cpuOpcodeFetch && !stQ.matchSeen && !stQ.inBreak && !stQ.request)
      |=> (stQ.request && stQ.active);
  endproperty
  a_opcode_match: assert property (p_opcode_match) else $error("opcode match missed");

  property p_vector;
    @(posedge clk) disable iff (!rst_n)
      monitorMode |-> (breakVector == VEC_MONITOR);
  endproperty
  a_vector: assert property (p_vector) else $error("wrong monitor vector");

  property p_ctrl_zero;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && rdStb && hitReg(wb_adr_i, OFF_CTRL_STAT)) |=> (stQ.rdata[5:0] == 6'h00);
  endproperty
  a_ctrl_zero: assert property (p_ctrl_zero) else $error("reserved control bits nonzero");

  // break sources and their timing

  property p_force_req;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && stQ.forcePending && cpuInstrStart && !stQ.request) |=> stQ.request;
  endproperty
  a_force_req: assert property (p_force_req) else $error("forced break not taken");

  property p_force_write;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && wrStb && hitReg(wb_adr_i, OFF_CTRL_STAT) && wByte[BIT_ACTIVE])
      |=> (stQ.active && (stQ.forcePending || stQ.request));
  endproperty
  a_force_write: assert property (p_force_write) else $error("forced break lost");

  property p_operand_req;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && stQ.pendingOperand && cpuInstrStart && !stQ.request)
      |=> (stQ.request && !stQ.reqOpcode);
  endproperty
  a_operand_req: assert property (p_operand_req) else $error("operand break not taken");

  property p_operand_wait;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && addrMatch && !cpuOpcodeFetch && !stQ.matchSeen && !stQ.inBreak &&
       !stQ.request && !stQ.pendingOperand && !stQ.forcePending) |=> stQ.pendingOperand;
  endproperty
  a_operand_wait: assert property (p_operand_wait) else $error("operand match not held");

  property p_disabled_quiet;
    @(posedge clk) disable iff (!rst_n) !stQ.enable |-> !addrMatch;
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("match while disabled");

  property p_rearm;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && stQ.matchSeen && !wrStb) |=> stQ.matchSeen;
  endproperty
  a_rearm: assert property (p_rearm) else $error("address re-armed without rewrite");

  property p_rti_only;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && stQ.inBreak && !cpuRtiDone) |=> stQ.inBreak;
  endproperty
  a_rti_only: assert property (p_rti_only) else $error("break left without return");

  property p_lowpower_no_req;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && lowPowerMode && !stQ.request && !stQ.pendingOperand && !stQ.forcePending)
      |=> !stQ.request;
  endproperty
  a_lowpower_no_req: assert property (p_lowpower_no_req) else $error("request in low power");

  // register side effects

  property p_active_clear;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && wrStb && hitReg(wb_adr_i, OFF_CTRL_STAT) && !wByte[BIT_ACTIVE] && !addrMatch)
      |=> !stQ.active;
  endproperty
  a_active_clear: assert property (p_active_clear) else $error("active bit not cleared");

  property p_enable_write;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && wrStb && hitReg(wb_adr_i, OFF_CTRL_STAT))
      |=> (stQ.enable == $past(wByte[BIT_ENABLE]));
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("enable bit not written");

  property p_addr_high;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && wrStb && hitReg(wb_adr_i, OFF_ADDR_HIGH)) |=> (stQ.addrHigh == $past(wByte));
  endproperty
  a_addr_high: assert property (p_addr_high) else $error("high address not written");

  property p_addr_low;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && wrStb && hitReg(wb_adr_i, OFF_ADDR_LOW)) |=> (stQ.addrLow == $past(wByte));
  endproperty
  a_addr_low: assert property (p_addr_low) else $error("low address not written");

  property p_wait_flag;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && waitExit && (stQ.request || stQ.forcePending)) |=> stQ.waitBreak;
  endproperty
  a_wait_flag: assert property (p_wait_flag) else $error("wait exit flag not set");

  property p_wait_clear;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && wrStb && hitReg(wb_adr_i, OFF_WAIT_EXIT) && !wByte[BIT_WAIT_BREAK] &&
       (!stQ.inBreak || stQ.clearEnable) && !(waitExit && (stQ.request || stQ.forcePending)))
      |=> !stQ.waitBreak;
  endproperty
  a_wait_clear: assert property (p_wait_clear) else $error("wait exit flag not cleared");

  property p_protect;
    @(posedge clk) disable iff (!rst_n)
      (clkEn && rdStb && hitReg(wb_adr_i, OFF_IRQ_STATUS) && stQ.inBreak && !stQ.clearEnable)
      |=> (($past(stQ.irqStatus) & ~stQ.irqStatus) == 2'h0);
  endproperty
  a_protect: assert property (p_protect) else $error("status cleared while protected");

  property p_wd_idle;
    @(posedge clk) disable iff (!rst_n) !stQ.inBreak |-> !watchdogDisable;
  endproperty
  a_wd_idle: assert property (p_wd_idle) else $error("watchdog off outside break");

  // bus handshake: one ack per request, and never two in a row

  property p_ack_follows;
    @(posedge clk) disable iff (!rst_n) (clkEn && busReq) |=> stQ.ack;
  endproperty
  a_ack_follows: assert property (p_ack_follows) else $error("request not acknowledged");

  property p_ack_pulse;
    @(posedge clk) disable iff (!rst_n) (clkEn && stQ.ack) |=> !stQ.ack;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("acknowledge held too long");
endmodule : abu_breakpoint

// ### abu_pkg.sv
// Purpose: constants for the address breakpoint unit
// Assumes: classic wishbone, byte-wide registers in the low bits of a 32-bit word
// Notes:   offsets are byte addresses on the register bus
package abu_pkg;
  localparam logic [15:0] OFF_WAIT_EXIT   = 16'hfe00;
  localparam logic [15:0] OFF_RSVD        = 16'hfe02;
  localparam logic [15:0] OFF_FLAG_PROT   = 16'hfe03;
  localparam logic [15:0] OFF_ADDR_HIGH   = 16'hfe09;
  localparam logic [15:0] OFF_ADDR_LOW    = 16'hfe0a;
  localparam logic [15:0] OFF_CTRL_STAT   = 16'hfe0b;
  localparam logic [15:0] OFF_IRQ_STATUS  = 16'hfe10;
  localparam logic [15:0] OFF_IRQ_MASK    = 16'hfe14;
  localparam int          BIT_ENABLE      = 7;
  localparam int          BIT_ACTIVE      = 6;
  localparam int          BIT_CLEAR_EN    = 7;
  localparam int          BIT_WAIT_BREAK  = 1;
  localparam int          IRQ_BREAK       = 0;
  localparam int          IRQ_WAIT_EXIT   = 1;
  localparam logic [7:0]  SWI_OPCODE      = 8'h83;
  localparam logic [15:0] VEC_NORMAL      = 16'hfffc;
  localparam logic [15:0] VEC_MONITOR     = 16'hfefc;
  localparam logic [7:0]  RESET_BYTE      = 8'h00;
  localparam logic [1:0]  RESET_IRQ       = 2'h0;
endpackage : abu_pkg

// ### abu_cpu_model.sv
// Purpose: core and integration side that answers a breakpoint request
// Assumes: request is a registered level from the breakpoint unit
// Notes:   the injected sequence starts late on purpose, as a busy core would
`timescale 1ns/1ps
module abu_cpu_model #(
  parameter int SwiDelay = 3
) (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic breakpointRequest,
  output logic      cpuSwiStart
);
  int cnt;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt         <= 0;
      cpuSwiStart <= 1'b0;
    end else begin
      cpuSwiStart <= 1'b0;
      if (breakpointRequest && !cpuSwiStart) begin
        cnt <= cnt + 1;
        if (cnt == SwiDelay) begin
          cpuSwiStart <= 1'b1;
          cnt         <= 0;
        end
      end
    end
  end
endmodule : abu_cpu_model

// ### testbench.sv
// Purpose: self-checking bench for the address breakpoint unit
// Assumes: cpu side driven here, injected interrupt start from the core model
// Notes:   checks run on the falling edge so registered outputs have settled
`timescale 1ns/1ps
module testbench;
  import abu_pkg::*;
  logic        clk = 0, rst_n = 0, cyc = 0, stb = 0, we = 0, valid = 0, opFetch = 0;
  logic        instrStart = 0, rtiDone = 0, waitExitP = 0, monitor = 0, highVolt = 1, lowPow = 0;
  logic        swiStart, request, beforeOp, brk, clrOk, tFreeze, wdDis, irq, ack;
  logic [15:0] adr = 0, cpuA = 0, vec;
  logic [31:0] wdat = 0, rdat;
  logic [7:0]  opc, q;
  int          nFail = 0, nCompared = 0;
  always #4 clk = ~clk;
  abu_breakpoint dut (.clk(clk), .rst_n(rst_n), .clkEn(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .cpuAddr(cpuA), .cpuAddrValid(valid), .cpuOpcodeFetch(opFetch),
    .cpuInstrStart(instrStart), .cpuSwiStart(swiStart), .cpuRtiDone(rtiDone),
    .lowPowerMode(lowPow), .waitExit(waitExitP), .monitorMode(monitor),
    .highTestVoltagePin(highVolt), .breakpointRequest(request), .breakBeforeOpcode(beforeOp),
    .injectOpcode(opc), .breakVector(vec), .breakState(brk), .statusClearAllowed(clrOk),
    .timerFreeze(tFreeze), .watchdogDisable(wdDis), .irq(irq));
  abu_cpu_model #(.SwiDelay(3)) core (.clk(clk), .rst_n(rst_n), .breakpointRequest(request),
    .cpuSwiStart(swiStart));
  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    nCompared++;
    if (seen !== exp) begin
      nFail++;
      $display("unexpected %s: expected %h, seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= {24'h00_0000, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) nFail++;
    q = rdat[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(negedge clk);
  endtask : bus
  task automatic rdChk(input string name, input logic [15:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00);
    chk(name, q, exp);
  endtask : rdChk
  task automatic fetch(input logic [15:0] a, input logic op);
    @(posedge clk);
    cpuA    <= a;
    valid   <= 1'b1;
    opFetch <= op;
    @(posedge clk);
    valid   <= 1'b0;
    opFetch <= 1'b0;
    @(negedge clk);
  endtask : fetch
  // waits for the core to take the break, then plays the break routine
  task automatic finishBreak(input logic [7:0] ctrlVal);
    int n = 0;
    while (brk !== 1'b1 && n < 40) begin
      @(negedge clk);
      n++;
    end
    chk("request after swi", request, 0);
    chk("timer freeze", tFreeze, 1);
    chk("watchdog off", wdDis, 1);
    chk("clear blocked", clrOk, 0);
    bus(1'b1, OFF_FLAG_PROT, 8'h80);
    chk("clear allowed", clrOk, 1);
    bus(1'b1, OFF_FLAG_PROT, 8'h00);
    bus(1'b1, OFF_CTRL_STAT, ctrlVal);
    @(posedge clk);
    rtiDone <= 1'b1;
    @(posedge clk);
    rtiDone <= 1'b0;
    @(negedge clk);
    chk("break state", brk, 0);
    chk("timer run", tFreeze, 0);
  endtask : finishBreak
  task automatic testReset;
    logic [15:0] offs [7] = '{OFF_WAIT_EXIT, OFF_RSVD, OFF_FLAG_PROT, OFF_ADDR_HIGH,
                              OFF_ADDR_LOW, OFF_CTRL_STAT, OFF_IRQ_MASK};
    foreach (offs[i]) rdChk("reset value", offs[i], 8'h00);
    bus(1'b1, OFF_CTRL_STAT, 8'h3f);
    rdChk("low control bits", OFF_CTRL_STAT, 8'h00);
    chk("idle request", request, 0);
    rdChk("unmapped", 16'hfe05, 8'h00);
  endtask : testReset
  task automatic testMatch;
    bus(1'b1, OFF_ADDR_HIGH, 8'h12);
    bus(1'b1, OFF_ADDR_LOW, 8'h34);
    bus(1'b1, OFF_CTRL_STAT, 8'h80);
    rdChk("addr high", OFF_ADDR_HIGH, 8'h12);
    fetch(16'h1334, 1'b1);
    chk("high byte differs", request, 0);
    fetch(16'h1234, 1'b1);
    chk("request", request, 1);
    chk("before opcode", beforeOp, 1);
    chk("inject opcode", opc, SWI_OPCODE);
    chk("vector", vec, VEC_NORMAL);
    @(posedge clk);
    monitor <= 1'b1;
    @(negedge clk);
    chk("monitor vector", vec, VEC_MONITOR);
    @(posedge clk);
    monitor <= 1'b0;
    rdChk("active set", OFF_CTRL_STAT, 8'hc0);
    finishBreak(8'h80);
    fetch(16'h1234, 1'b1);
    chk("repeat match", request, 0);
  endtask : testMatch
  task automatic testOperand;
    fetch(16'h2000, 1'b1);
    bus(1'b1, OFF_ADDR_HIGH, 8'h20);
    bus(1'b1, OFF_ADDR_LOW, 8'h01);
    @(posedge clk);
    lowPow <= 1'b1;
    fetch(16'h2001, 1'b1);
    chk("low power match", request, 0);
    @(posedge clk);
    lowPow <= 1'b0;
    fetch(16'h2001, 1'b0);
    chk("operand waits", request, 0);
    @(posedge clk);
    instrStart <= 1'b1;
    @(posedge clk);
    instrStart <= 1'b0;
    @(negedge clk);
    chk("operand break", request, 1);
    finishBreak(8'h00);
  endtask : testOperand
  task automatic testForced;
    bus(1'b1, OFF_CTRL_STAT, 8'h40);
    chk("forced waits", request, 0);
    @(posedge clk);
    instrStart <= 1'b1;
    @(posedge clk);
    instrStart <= 1'b0;
    waitExitP  <= 1'b1;
    @(posedge clk);
    waitExitP  <= 1'b0;
    @(negedge clk);
    chk("forced break", request, 1);
    rdChk("wait break flag", OFF_WAIT_EXIT, 8'h02);
    finishBreak(8'h00);
    bus(1'b1, OFF_WAIT_EXIT, 8'h00);
    rdChk("wait flag cleared", OFF_WAIT_EXIT, 8'h00);
  endtask : testForced
  task automatic testIrq;
    chk("irq masked", irq, 0);
    bus(1'b1, OFF_IRQ_MASK, 8'h03);
    chk("irq raised", irq, 1);
    rdChk("irq status", OFF_IRQ_STATUS, 8'h03);
    chk("irq cleared", irq, 0);
    rdChk("status after read", OFF_IRQ_STATUS, 8'h00);
  endtask : testIrq
  task automatic printVerdict;
    $display("compared %0d, mismatches %0d", nCompared, nFail);
    if (nFail == 0 && nCompared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : printVerdict
  initial begin
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    testReset;
    testMatch;
    testOperand;
    testForced;
    testIrq;
    printVerdict;
  end
  initial begin
    #(8 * 4000);
    nFail++;
    printVerdict;
  end
endmodule : testbench
